// ==== logic/sdc_cmd_if.sv ====
`timescale 1ns/100ps
module sdc_cmd_if #(
    parameter int DW      = 16,
    parameter int MEM_RB  = 2,
    parameter int MEM_CB  = 4
) (
    input  wire logic              mclk_i,
    input  wire logic              rst_n_i,
    input  wire logic              cke_i,
    input  wire logic              cs_n_i,
    input  wire logic              ras_n_i,
    input  wire logic              cas_n_i,
    input  wire logic              we_n_i,
    input  wire logic              bank_select_lo_i,
    input  wire logic              bank_select_hi_i,
    input  wire logic [11:0]       addr_i,
    input  wire logic [DW/8-1:0]   dqm_i,
    input  wire logic [DW-1:0]     dq_i,
    output logic      [DW-1:0]     dq_o,
    output logic      [DW/8-1:0]   dq_oe_n_o,
    output logic      [3:0]        bank_open_o,
    output logic      [3:0]        bank_idle_o,
    output logic      [11:0]       mode_reg_o,
    output logic      [11:0]       refresh_row_o,
    output logic                   cmd_error_o
);
    localparam int BY    = DW / 8;
    localparam int IDX_W = 2 + MEM_RB + MEM_CB;

    logic [11:0]          mode_reg;
    logic [11:0]          refresh_row_reg;
    logic                 cmd_error_reg;
    logic [3:0]           bank_open_reg;
    logic [11:0]          row_reg [4];
    logic [2:0]           trp_cnt_reg [4];
    logic [DW-1:0]        mem_reg [2**IDX_W];
    sdc_pkg::sdc_burst_t  bst_state_reg;
    sdc_pkg::sdc_burst_t  bst_state_next;
    logic [1:0]           bst_bank_reg;
    logic [8:0]           bst_col_reg;
    logic [9:0]           bst_beat_reg;
    logic [9:0]           bst_len_reg;
    logic                 bst_ap_reg;
    logic                 bst_il_reg;
    logic [DW-1:0]        pipe_d_reg [3];
    logic [2:0]           pipe_v_reg;
    logic [BY-1:0]        dqm_d1_reg;
    logic [BY-1:0]        dqm_d2_reg;

    function automatic logic [8:0] beat_col(input logic [8:0] start, input logic [9:0] beat,
                                            input logic [9:0] len, input logic il);
        logic [8:0] mask;
        mask = 9'(len - 10'h1);
        if (il)
            beat_col = (start & ~mask) | ((start ^ beat[8:0]) & mask);
        else
            beat_col = (start & ~mask) | (9'(start + beat[8:0]) & mask);
    endfunction

    // decode: deselect or clock enable low means no command
    sdc_pkg::sdc_cmd_t cmd;
    wire       cmd_en = cke_i & ~cs_n_i;
    assign     cmd    = sdc_pkg::sdc_cmd_t'({ras_n_i, cas_n_i, we_n_i});
    wire       is_act = cmd_en & (cmd == sdc_pkg::CMD_ACT);
    wire       is_rd  = cmd_en & (cmd == sdc_pkg::CMD_READ);
    wire       is_wr  = cmd_en & (cmd == sdc_pkg::CMD_WRITE);
    wire       is_bst = cmd_en & (cmd == sdc_pkg::CMD_BST);
    wire       is_pre = cmd_en & (cmd == sdc_pkg::CMD_PRE);
    wire       is_ref = cmd_en & (cmd == sdc_pkg::CMD_REF);
    wire       is_lmr = cmd_en & (cmd == sdc_pkg::CMD_LMR);
    wire [1:0] bank_sel = {bank_select_hi_i, bank_select_lo_i};

    wire [3:0] bank_idle;
    genvar g;
    for (g = 0; g < 4; g++)
    begin : g_idle
        assign bank_idle[g] = ~bank_open_reg[g] & (trp_cnt_reg[g] == 3'h0);
    end

    // mode register fields
    wire [2:0] bl_code   = mode_reg[sdc_pkg::MODE_BL_LSB +: 3];
    wire       full_page = (bl_code == sdc_pkg::BL_FULL_PAGE);
    wire [9:0] bl_len    = full_page ? sdc_pkg::FULL_PAGE_LEN :
                           (bl_code[2] ? 10'h1 : (10'h1 << bl_code[1:0]));
    wire [9:0] wr_len    = mode_reg[sdc_pkg::MODE_WB_BIT] ? 10'h1 : bl_len;
    wire       cl3       = (mode_reg[sdc_pkg::MODE_CL_LSB +: 3] == sdc_pkg::CL_THREE);

    // column accesses only reach an open bank; others are flagged
    wire       rd_go   = is_rd & bank_open_reg[bank_sel];
    wire       wr_go   = is_wr & bank_open_reg[bank_sel];
    wire       acc_go  = rd_go | wr_go;
    wire [9:0] go_len  = wr_go ? wr_len : bl_len;
    // a new access or a terminate takes over the running burst
    wire       brst_on = (bst_state_reg != sdc_pkg::B_IDLE) & ~is_bst & ~acc_go
                         & bank_open_reg[bst_bank_reg];
    wire [1:0] cur_bank = acc_go ? bank_sel : bst_bank_reg;
    wire [8:0] cur_col  = acc_go ? addr_i[8:0] :
                          beat_col(bst_col_reg, bst_beat_reg, bst_len_reg, bst_il_reg);
    wire       cur_rd   = rd_go | (brst_on & (bst_state_reg == sdc_pkg::B_READ));
    wire       cur_wr   = wr_go | (brst_on & (bst_state_reg == sdc_pkg::B_WRITE));
    wire       last     = acc_go ? (go_len == 10'h1) : (bst_beat_reg == 10'(bst_len_reg - 10'h1));
    wire       ap_on    = acc_go ? (addr_i[sdc_pkg::AP_BIT] & ~full_page) : bst_ap_reg;
    // precharge fires on the final beat, the earliest point this model allows
    wire       ap_fire  = ap_on & (acc_go | brst_on) & last;
    wire [IDX_W-1:0] idx = {cur_bank, row_reg[cur_bank][MEM_RB-1:0], cur_col[MEM_CB-1:0]};

    wire [3:0] pre_mask   = addr_i[sdc_pkg::AP_BIT] ? 4'hf : (4'h1 << bank_sel);
    wire [3:0] close_mask = (is_pre ? pre_mask : 4'h0) | (ap_fire ? (4'h1 << cur_bank) : 4'h0);
    wire       bad_cmd    = (is_act & ~bank_idle[bank_sel]) | ((is_rd | is_wr) & ~acc_go)
                            | ((is_lmr | is_ref) & (bank_idle != 4'hf));

    always_comb
    begin
        bst_state_next = bst_state_reg;
        case (bst_state_reg)
            sdc_pkg::B_IDLE:
            begin
                if (acc_go && !last)
                    bst_state_next = rd_go ? sdc_pkg::B_READ : sdc_pkg::B_WRITE;
            end
            sdc_pkg::B_READ, sdc_pkg::B_WRITE:
            begin
                if (acc_go)
                    bst_state_next = last ? sdc_pkg::B_IDLE : (rd_go ? sdc_pkg::B_READ : sdc_pkg::B_WRITE);
                else if (!brst_on || last)
                    bst_state_next = sdc_pkg::B_IDLE;
            end
            default: bst_state_next = sdc_pkg::B_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            bst_state_reg <= sdc_pkg::B_IDLE;
            bst_bank_reg  <= 2'h0;
            bst_col_reg   <= 9'h0;
            bst_beat_reg  <= 10'h0;
            bst_len_reg   <= 10'h1;
            bst_ap_reg    <= 1'b0;
            bst_il_reg    <= 1'b0;
        end
        else
        begin
            bst_state_reg <= bst_state_next;
            if (acc_go)
            begin
                bst_bank_reg <= bank_sel;
                bst_col_reg  <= addr_i[8:0];
                bst_beat_reg <= 10'h1;
                bst_len_reg  <= go_len;
                bst_ap_reg   <= ap_on;
                bst_il_reg   <= mode_reg[sdc_pkg::MODE_BT_BIT];
            end
            else if (brst_on)
                bst_beat_reg <= 10'(bst_beat_reg + 10'h1);
        end
    end

    // per-bank open state, open row and precharge countdown
    always_ff @(posedge mclk_i)
    begin
        for (int b = 0; b < 4; b++)
        begin
            if (!rst_n_i)
            begin
                bank_open_reg[b] <= 1'b0;
                row_reg[b]       <= 12'h0;
                trp_cnt_reg[b]   <= 3'h0;
            end
            else if (close_mask[b] && bank_open_reg[b])
            begin
                bank_open_reg[b] <= 1'b0;
                trp_cnt_reg[b]   <= sdc_pkg::TRP_CNT;
            end
            else if (is_act && bank_sel == 2'(b) && bank_idle[b])
            begin
                bank_open_reg[b] <= 1'b1;
                row_reg[b]       <= addr_i;
            end
            else if (trp_cnt_reg[b] != 3'h0)
                trp_cnt_reg[b] <= 3'(trp_cnt_reg[b] - 3'h1);
        end
    end

    // write data and mask are taken on the same edge as the beat
    always_ff @(posedge mclk_i)
    begin
        for (int j = 0; j < BY; j++)
            if (cur_wr && !dqm_i[j])
                mem_reg[idx][j*8 +: 8] <= dq_i[j*8 +: 8];
    end

    always_ff @(posedge mclk_i)
    begin
        if (!rst_n_i)
        begin
            mode_reg        <= sdc_pkg::MODE_RESET;
            refresh_row_reg <= 12'h0;
            cmd_error_reg   <= 1'b0;
            pipe_v_reg      <= 3'h0;
            dqm_d1_reg      <= {BY{1'b1}};
            dqm_d2_reg      <= {BY{1'b1}};
            for (int k = 0; k < 3; k++)
                pipe_d_reg[k] <= '0;
        end
        else
        begin
            if (is_lmr)
                mode_reg <= addr_i;
            if (is_ref)
                refresh_row_reg <= 12'(refresh_row_reg + 12'h1);
            cmd_error_reg <= bad_cmd;
            pipe_v_reg    <= {pipe_v_reg[1:0], cur_rd};
            pipe_d_reg[0] <= mem_reg[idx];
            pipe_d_reg[1] <= pipe_d_reg[0];
            pipe_d_reg[2] <= pipe_d_reg[1];
            dqm_d1_reg    <= dqm_i;
            dqm_d2_reg    <= dqm_d1_reg;
        end
    end

    // latency select picks a stage so data is valid at the command edge plus latency
    wire rd_valid = cl3 ? pipe_v_reg[2] : pipe_v_reg[1];
    assign dq_o          = cl3 ? pipe_d_reg[2] : pipe_d_reg[1];
    assign dq_oe_n_o     = ~({BY{rd_valid}} & ~dqm_d2_reg);
    assign bank_open_o   = bank_open_reg;
    assign bank_idle_o   = bank_idle;
    assign mode_reg_o    = mode_reg;
    assign refresh_row_o = refresh_row_reg;
    assign cmd_error_o   = cmd_error_reg;

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    property p_pre_all;
        is_pre && addr_i[sdc_pkg::AP_BIT] |=> bank_open_o == 4'h0;
    endproperty
    a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open");

    property p_pre_one;
        is_pre && !addr_i[sdc_pkg::AP_BIT] |=> !bank_open_o[$past(bank_sel)];
    endproperty
    a_pre_one: assert property (p_pre_one) else $error("bank precharge left bank open");

    property p_trp;
        close_mask[0] && bank_open_o[0] |=> !bank_idle_o[0] [*4] ##1 bank_idle_o[0];
    endproperty
    a_trp: assert property (p_trp) else $error("bank idle timing wrong after precharge");

    property p_act;
        is_act && bank_idle_o[bank_sel] |=> bank_open_o[$past(bank_sel)] && row_reg[$past(bank_sel)] == $past(addr_i);
    endproperty
    a_act: assert property (p_act) else $error("activate did not open the row");

    property p_lmr;
        is_lmr |=> mode_reg_o == $past(addr_i);
    endproperty
    a_lmr: assert property (p_lmr) else $error("mode register not loaded");

    property p_ref;
        is_ref |=> refresh_row_o == 12'($past(refresh_row_o) + 12'h1);
    endproperty
    a_ref: assert property (p_ref) else $error("refresh counter did not advance");

    property p_cke;
        !cke_i |=> $stable(mode_reg_o) && $stable(refresh_row_o);
    endproperty
    a_cke: assert property (p_cke) else $error("command taken with clock enable low");

    property p_dqm_hiz;
        dqm_i[0] |-> ##2 dq_oe_n_o[0];
    endproperty
    a_dqm_hiz: assert property (p_dqm_hiz) else $error("masked read byte was driven");

    property p_ap;
        ap_fire |=> !bank_open_o[$past(cur_bank)];
    endproperty
    a_ap: assert property (p_ap) else $error("auto precharge did not close bank");

    property p_noap;
        acc_go && !addr_i[sdc_pkg::AP_BIT] && !is_pre |=> bank_open_o[$past(bank_sel)];
    endproperty
    a_noap: assert property (p_noap) else $error("row closed without precharge");

    property p_bst;
        is_bst |=> bst_state_reg == sdc_pkg::B_IDLE;
    endproperty
    a_bst: assert property (p_bst) else $error("burst survived terminate");

    c_write_burst: cover property (wr_go ##1 cur_wr ##1 cur_wr);
    c_auto_pre:    cover property (ap_fire ##1 !bank_open_o[0]);
    c_read_cl3:    cover property (rd_go && cl3 ##3 !dq_oe_n_o[0]);
    c_refresh:     cover property (is_ref ##1 is_ref);
endmodule

// ==== logic/sdc_pkg.sv ====
package sdc_pkg;
    // command code is {ras_n, cas_n, we_n} with chip select low
    typedef enum logic [2:0] {
        CMD_LMR   = 3'h0,
        CMD_REF   = 3'h1,
        CMD_PRE   = 3'h2,
        CMD_ACT   = 3'h3,
        CMD_WRITE = 3'h4,
        CMD_READ  = 3'h5,
        CMD_BST   = 3'h6,
        CMD_NOP   = 3'h7
    } sdc_cmd_t;

    typedef enum logic [1:0] {
        B_IDLE  = 2'h0,
        B_READ  = 2'h1,
        B_WRITE = 2'h2
    } sdc_burst_t;

    localparam int          ROW_W        = 12;
    localparam int          COL_W        = 9;
    localparam int          BANKS        = 4;
    localparam int          AP_BIT       = 10;
    localparam int          MODE_BL_LSB  = 0;
    localparam int          MODE_BT_BIT  = 3;
    localparam int          MODE_CL_LSB  = 4;
    localparam int          MODE_WB_BIT  = 9;
    localparam logic [2:0]  BL_FULL_PAGE = 3'h7;
    localparam logic [2:0]  CL_THREE     = 3'h3;
    localparam logic [9:0]  FULL_PAGE_LEN = 10'h200;
    localparam logic [11:0] MODE_RESET   = 12'h020;
    localparam int          REFRESH_CMDS = 4096;
    localparam int          CLK_PERIOD_PS = 5000;
    // row precharge time is a plain default, not a part figure
    localparam int          ROW_PRECHARGE_TIME_PS = 20000;
    localparam int          TRP_CYC = (ROW_PRECHARGE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [2:0]  TRP_CNT = 3'(TRP_CYC);
endpackage

// ==== verification/sdc_ctrl_model.sv ====
`timescale 1ns/100ps
module sdc_ctrl_model (
    input  wire logic        mclk_i,
    output logic             cke_o,
    output logic             cs_n_o,
    output logic             ras_n_o,
    output logic             cas_n_o,
    output logic             we_n_o,
    output logic             bank_select_lo_o,
    output logic             bank_select_hi_o,
    output logic [11:0]      addr_o,
    output logic [1:0]       dqm_o,
    output logic [15:0]      dq_o
);
    logic [3:0] open_q;
    initial
    begin
        {cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o} = 5'h1f;
        {bank_select_hi_o, bank_select_lo_o, addr_o, dqm_o, dq_o} = '0;
        open_q = 4'h0;
    end
    // en is {cke, cs_n}; everything changes just after an edge and holds one cycle
    task automatic cmd(input logic [2:0] c, input logic [1:0] b, input logic [11:0] a,
                       input logic [15:0] d, input logic [1:0] m, input logic [1:0] en);
        @(posedge mclk_i);
        {cke_o, cs_n_o} <= en;
        {ras_n_o, cas_n_o, we_n_o} <= c;
        {bank_select_hi_o, bank_select_lo_o} <= b;
        addr_o <= a;
        dq_o <= d;
        dqm_o <= m;
        if ((c == sdc_pkg::CMD_READ || c == sdc_pkg::CMD_WRITE) && a[10] && en == 2'h2)
            open_q[b] = 1'b0;
    endtask
    // released data lines show the inverse of the last value
    task automatic nop(input int n);
        repeat (n) cmd(sdc_pkg::CMD_NOP, 2'h0, 12'h000, ~dq_o, 2'h0, 2'h2);
    endtask
    task automatic pre(input logic all, input logic [1:0] b);
        cmd(sdc_pkg::CMD_PRE, b, {1'b0, all, 10'h000}, ~dq_o, 2'h0, 2'h2);
        if (all)
            open_q = 4'h0;
        else
            open_q[b] = 1'b0;
        nop(sdc_pkg::TRP_CYC);
    endtask
    task automatic act(input logic [1:0] b, input logic [11:0] row);
        if (open_q[b])
            pre(1'b0, b);
        cmd(sdc_pkg::CMD_ACT, b, row, ~dq_o, 2'h0, 2'h2);
        open_q[b] = 1'b1;
    endtask
    task automatic ref_all(input logic [11:0] a);
        if (|open_q)
            pre(1'b1, 2'h0);
        cmd(sdc_pkg::CMD_REF, 2'h0, a, ~dq_o, 2'h0, 2'h2);
        nop(1);
    endtask
    task automatic lmr(input logic [11:0] op);
        if (|open_q)
            pre(1'b1, 2'h0);
        cmd(sdc_pkg::CMD_LMR, 2'h0, op, ~dq_o, 2'h0, 2'h2);
        nop(2);
    endtask
endmodule

// ==== verification/testbench.sv ====
`timescale 1ns/100ps
module testbench;
    logic        mclk_i, rst_n_i, cke, cs_n, ras_n, cas_n, we_n, ba_lo, ba_hi, cmd_err;
    logic [11:0] addr, mode_reg, refresh_row;
    logic [15:0] dq_w, dq_rd;
    logic [1:0]  dqm, oe_n;
    logic [3:0]  bank_open, bank_idle, open_m;
    logic [15:0] mem [int];
    int          bad_count = 0, compares = 0, seed = 5, cyc = 0, refc = 0;
    int          cl_m = 2;
    logic        il_m, ws_m;

    sdc_ctrl_model i_ctrl (.mclk_i(mclk_i), .cke_o(cke), .cs_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n),
        .we_n_o(we_n), .bank_select_lo_o(ba_lo), .bank_select_hi_o(ba_hi), .addr_o(addr), .dqm_o(dqm),
        .dq_o(dq_w));
    sdc_cmd_if i_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cke_i(cke), .cs_n_i(cs_n), .ras_n_i(ras_n),
        .cas_n_i(cas_n), .we_n_i(we_n), .bank_select_lo_i(ba_lo), .bank_select_hi_i(ba_hi), .addr_i(addr),
        .dqm_i(dqm), .dq_i(dq_w), .dq_o(dq_rd), .dq_oe_n_o(oe_n), .bank_open_o(bank_open),
        .bank_idle_o(bank_idle), .mode_reg_o(mode_reg), .refresh_row_o(refresh_row), .cmd_error_o(cmd_err));

    initial
    begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    task automatic print_verdict;
        if (bad_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge mclk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            bad_count++;
            print_verdict;
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    function automatic int key(input logic [1:0] b, input int row, input int col);
        return b * 64 + row * 16 + (col & 15);
    endfunction

    // column of beat k in a burst of four, in the order the loaded mode asks for
    function automatic int col_of(input int c, input int k);
        return (c & ~3) | ((il_m ? (c ^ k) : (c + k)) & 3);
    endfunction

    task automatic load(input logic [11:0] op);
        i_ctrl.lmr(op);
        cl_m = (op[6:4] == 3'h3) ? 3 : 2;
        il_m = op[3];
        ws_m = op[9];
        #1;
        check(16'(mode_reg), 16'(op), "mode load");
    endtask

    task automatic sc;
        i_ctrl.nop(1);
        #1;
        check(16'({bank_open, cmd_err}), 16'({open_m, 1'b0}), "open banks");
    endtask

    // nb below 4 cuts the burst with a terminate; mk randomises byte masks
    task automatic wr(input logic [1:0] b, input int row, input int c, input logic ap, input int nb,
                      input logic mk);
        logic [15:0] d;
        logic [1:0]  m;
        int          kk;
        for (int k = 0; k < 4; k++)
        begin
            d = 16'($random(seed));
            m = mk ? 2'($random(seed)) : 2'h0;
            kk = key(b, row, col_of(c, k));
            if (k == 0)
                i_ctrl.cmd(sdc_pkg::CMD_WRITE, b, 12'(c) | {1'b0, ap, 10'h000}, d, m, 2'h2);
            else if (k < nb)
                i_ctrl.cmd(sdc_pkg::CMD_NOP, b, 12'h000, d, m, 2'h2);
            else if (k == nb)
                i_ctrl.cmd(sdc_pkg::CMD_BST, b, 12'h000, d, m, 2'h2);
            else
                i_ctrl.nop(1);
            // single-location write mode stores only the beat taken with the command
            if (k < nb && (k == 0 || !ws_m))
                mem[kk] = {m[1] ? mem[kk][15:8] : d[15:8], m[0] ? mem[kk][7:0] : d[7:0]};
        end
        if (ap && (nb == 4 || ws_m))
            open_m[b] = 1'b0;
    endtask

    // after edge j past the command, beat j-latency+1 is out, gated by the mask taken at edge j-1
    task automatic rd(input logic [1:0] b, input int row, input int c, input logic ap);
        logic [1:0]  m [7];
        logic [15:0] msk;
        int          kk;
        int          bt;
        for (int k = 0; k < 7; k++)
            m[k] = 2'($random(seed));
        i_ctrl.cmd(sdc_pkg::CMD_READ, b, 12'(c) | {1'b0, ap, 10'h000}, ~dq_w, m[0], 2'h2);
        for (int j = 0; j < 6; j++)
        begin
            i_ctrl.cmd(sdc_pkg::CMD_NOP, b, 12'h000, 16'($random(seed)), m[j + 1], 2'h2);
            if (j > 0)
            begin
                #1;
                bt = j - cl_m + 1;
                if (bt >= 0 && bt < 4)
                begin
                    kk = key(b, row, col_of(c, bt));
                    msk = {{8{~m[j - 1][1]}}, {8{~m[j - 1][0]}}};
                    check(16'(oe_n), 16'(m[j - 1]), "read enable");
                    check(dq_rd & msk, mem[kk] & msk, "read data");
                end
                else
                    check(16'(oe_n), 16'h0003, "read idle");
            end
        end
        if (ap)
            open_m[b] = 1'b0;
    endtask

    // exp counts the cycles still owed to the precharge when the wait starts
    task automatic wait_idle(input logic [1:0] b, input int exp);
        int n;
        n = 0;
        check(16'(bank_idle[b]), 16'h0000, "idle early");
        while (bank_idle[b] !== 1'b1 && n < 8)
        begin
            i_ctrl.nop(1);
            #1;
            n++;
        end
        check(16'(bank_idle[b]), 16'h0001, "idle late");
        check(16'(n), 16'(exp), "precharge cycles");
    endtask

    initial
    begin
        rst_n_i = 1'b0;
        open_m = 4'h0;
        repeat (4) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        #1;
        check(16'({bank_open, bank_idle, oe_n, cmd_err}), 16'h007e, "reset state");
        check(16'(mode_reg), 16'h0020, "reset mode");
        check(16'(refresh_row), 16'h0000, "reset refresh row");
        // burst of four, sequential, latency two
        load(12'h022);
        i_ctrl.cmd(sdc_pkg::CMD_ACT, 2'h1, 12'h001, ~dq_w, 2'h0, 2'h3);
        i_ctrl.cmd(sdc_pkg::CMD_ACT, 2'h1, 12'h001, ~dq_w, 2'h0, 2'h0);
        sc;
        i_ctrl.act(2'h0, 12'h001);
        i_ctrl.act(2'h2, 12'h002);
        open_m = 4'h5;
        sc;
        wr(2'h0, 1, 5, 1'b0, 4, 1'b0);
        wr(2'h0, 1, 5, 1'b0, 2, 1'b1);
        rd(2'h0, 1, 5, 1'b0);
        sc;
        wr(2'h2, 2, 2, 1'b1, 4, 1'b0);
        sc;
        wait_idle(2'h2, sdc_pkg::TRP_CYC);
        i_ctrl.act(2'h1, 12'h003);
        i_ctrl.cmd(sdc_pkg::CMD_ACT, 2'h1, 12'h001, ~dq_w, 2'h0, 2'h2);
        i_ctrl.nop(1);
        #1;
        check(16'(cmd_err), 16'h0001, "refused activate");
        i_ctrl.pre(1'b0, 2'h0);
        open_m = 4'h2;
        sc;
        i_ctrl.pre(1'b1, 2'h0);
        open_m = 4'h0;
        sc;
        check(16'(bank_idle), 16'h000f, "all idle");
        i_ctrl.act(2'h2, 12'h002);
        open_m = 4'h4;
        rd(2'h2, 2, 2, 1'b1);
        sc;
        // the read task and sc run three cycles past the closing beat before the wait starts
        wait_idle(2'h2, sdc_pkg::TRP_CYC - 3);
        for (int i = 0; i < 3; i++)
        begin
            i_ctrl.ref_all(12'($random(seed)));
            refc++;
            #1;
            check(16'(refresh_row), 16'(refc), "refresh row");
        end
        // latency three, interleaved order, single-location writes
        load(12'h23a);
        i_ctrl.act(2'h0, 12'h001);
        open_m = 4'h1;
        wr(2'h0, 1, 5, 1'b0, 4, 1'b1);
        rd(2'h0, 1, 6, 1'b1);
        sc;
        wait_idle(2'h0, sdc_pkg::TRP_CYC - 3);
        print_verdict;
    end
endmodule
